/* core/cc_clk_ctrl.sv */
/*
  System clock controller: source select with glitch-free switching,
  external oscillator failure fallback, PLL configuration, bus tick
  dividers and low-power clock gating.
  Assumes pins are asynchronous and control ports come from CLK logic.
*/
`timescale 1ns/100ps
module cc_clk_ctrl
  import cc_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic [1:0]           SRC_REQ,
  input  wire logic                 EXT_OSC_EN_REQ,
  input  wire logic                 MAIN_PLL_EN_REQ,
  input  wire cc_pkg::cc_pll_cfg_s  MAIN_PLL_CFG,
  input  wire logic                 AUDIO_PLL_EN_REQ,
  input  wire cc_pkg::cc_apll_cfg_s AUDIO_PLL_CFG,
  input  wire logic                 RC_RDY,
  input  wire logic                 EXT_RDY,
  input  wire logic                 PLL_LOCK,
  input  wire logic                 EXT_FAIL,
  input  wire logic                 FAIL_IRQ_EN,
  input  wire logic                 FAIL_IRQ_CLR,
  input  wire logic [2:0]           AHB_DIV,
  input  wire logic [2:0]           APB1_DIV,
  input  wire logic [2:0]           APB2_DIV,
  input  wire logic                 LP_ENTER,
  input  wire cc_pkg::cc_lp_e       LP_MODE,
  input  wire logic                 WAKE,
  output logic                      RC_OSC_EN,
  output logic                      EXT_OSC_EN,
  output logic                      MAIN_PLL_EN,
  output cc_pkg::cc_pll_cfg_s       MAIN_PLL_CFG_O,
  output logic                      AUDIO_PLL_EN,
  output cc_pkg::cc_apll_cfg_s      AUDIO_PLL_CFG_O,
  output logic [2:0]                SRC_GATE,
  output logic [1:0]                SRC_STAT,
  output logic                      SW_BUSY,
  output logic                      FAIL_FLAG,
  output logic                      FAIL_IRQ,
  output logic                      CORE_CLK_EN,
  output logic                      PERIPH_CLK_EN,
  output logic                      CORE_DOMAIN_EN,
  output logic                      RTC_DOMAIN_EN,
  output cc_pkg::cc_lp_e            LP_STAT,
  output logic                      AHB_TICK,
  output logic                      APB1_TICK,
  output logic                      APB2_TICK
);

  import cc_pkg::*;

  logic [CC_PIN_W-1:0] pin_s;
  logic                rc_s;
  logic                ext_s;
  logic                lock_s;
  logic                fail_s;
  logic                wake_s;
  logic                fail_q_reg;
  logic                wake_q_reg;
  logic                fail_rise;
  logic                wake_rise;
  cc_sw_e              sw_reg;
  logic [3:0]          gap_reg;
  logic [1:0]          tgt_reg;
  logic [1:0]          cur_reg;
  logic [2:0]          gate_reg;
  logic                wake_pend_reg;
  logic                sw_go;
  logic [1:0]          sw_tgt;
  logic                fail_dep;
  logic                req_ok;
  logic                flag_next;
  cc_lp_e              lp_reg;
  logic                deep;

  // Pin levels pass two flops before use
  cc_sync #(
    .W (CC_PIN_W)
  ) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({WAKE, EXT_FAIL, PLL_LOCK, EXT_RDY, RC_RDY}),
    .q   (pin_s)
  );

  assign rc_s   = pin_s[CC_PIN_RC];
  assign ext_s  = pin_s[CC_PIN_EXT];
  assign lock_s = pin_s[CC_PIN_LOCK];
  assign fail_s = pin_s[CC_PIN_FAIL];
  assign wake_s = pin_s[CC_PIN_WAKE];

  // Edge detect on synchronised levels
  always_ff @(posedge CLK) begin
    if (RST) begin
      fail_q_reg <= 1'b0;
      wake_q_reg <= 1'b0;
    end else begin
      fail_q_reg <= fail_s;
      wake_q_reg <= wake_s;
    end
  end

  assign fail_rise = fail_s & ~fail_q_reg;
  assign wake_rise = wake_s & ~wake_q_reg;
  assign deep      = (lp_reg == CC_LP_STOP) || (lp_reg == CC_LP_STANDBY);

  // Current source depends on the failed oscillator
  assign fail_dep = fail_s & ((cur_reg == CC_SRC_EXT) ||
                              ((cur_reg == CC_SRC_PLL) && MAIN_PLL_CFG_O.ref_ext));

  // Requested source is usable only when running and healthy
  always_comb begin
    req_ok = 1'b0;
    case (SRC_REQ)
      CC_SRC_RC:  req_ok = rc_s;
      CC_SRC_EXT: req_ok = ext_s & ~fail_s & EXT_OSC_EN;
      CC_SRC_PLL: req_ok = lock_s & MAIN_PLL_EN & ~(fail_s & MAIN_PLL_CFG_O.ref_ext);
      default:    req_ok = 1'b0;
    endcase
  end

  // Pick the next switch: fallback and wake first, then software
  always_comb begin
    sw_go  = 1'b0;
    sw_tgt = CC_SRC_RC;
    if (!deep && sw_reg == CC_SW_RUN) begin
      if (fail_dep || wake_pend_reg) begin
        sw_go  = 1'b1;
        sw_tgt = CC_SRC_RC;
      end else if (SRC_REQ != cur_reg && req_ok) begin
        sw_go  = 1'b1;
        sw_tgt = SRC_REQ;
      end
    end
  end

  // Break-before-make switch: all gates off for the gap, then the new one
  always_ff @(posedge CLK) begin
    if (RST) begin
      sw_reg   <= CC_SW_RUN;
      gap_reg  <= 4'h0;
      tgt_reg  <= CC_SRC_RC;
      cur_reg  <= CC_SRC_RC;
      gate_reg <= cc_gate(CC_SRC_RC);
    end else if (deep) begin
      sw_reg   <= CC_SW_RUN;
      gate_reg <= CC_GATE_OFF;
    end else begin
      case (sw_reg)
        CC_SW_RUN: begin
          if (sw_go) begin
            sw_reg   <= CC_SW_GAP;
            gap_reg  <= CC_GAP_CYC;
            tgt_reg  <= sw_tgt;
            gate_reg <= CC_GATE_OFF;
          end
        end
        CC_SW_GAP: begin
          if (gap_reg <= 4'h1) begin
            sw_reg   <= CC_SW_RUN;
            cur_reg  <= tgt_reg;
            gate_reg <= cc_gate(tgt_reg);
          end else begin
            gap_reg  <= gap_reg - 4'h1;
          end
        end
        default: begin
          sw_reg   <= CC_SW_RUN;
        end
      endcase
    end
  end

  assign SRC_GATE = gate_reg;
  assign SRC_STAT = cur_reg;

  // Busy while a switch is in flight
  always_ff @(posedge CLK) begin
    if (RST) begin
      SW_BUSY <= 1'b0;
    end else begin
      SW_BUSY <= (sw_reg == CC_SW_GAP) || sw_go;
    end
  end

  // Failure flag is sticky, set wins over clear
  assign flag_next = fail_rise | (FAIL_FLAG & ~FAIL_IRQ_CLR);

  always_ff @(posedge CLK) begin
    if (RST) begin
      FAIL_FLAG <= 1'b0;
      FAIL_IRQ  <= 1'b0;
    end else begin
      FAIL_FLAG <= flag_next;
      FAIL_IRQ  <= flag_next & FAIL_IRQ_EN;
    end
  end

  // Low-power mode state; a wake edge returns to run
  always_ff @(posedge CLK) begin
    if (RST) begin
      lp_reg        <= CC_LP_RUN;
      wake_pend_reg <= 1'b0;
    end else begin
      if (lp_reg == CC_LP_RUN) begin
        if (LP_ENTER) begin
          lp_reg <= LP_MODE;
        end
      end else if (wake_rise) begin
        lp_reg <= CC_LP_RUN;
        if (deep) begin
          wake_pend_reg <= 1'b1;
        end
      end
      if (sw_go) begin
        wake_pend_reg <= 1'b0;
      end
    end
  end

  // Oscillator, PLL and domain enables follow the mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      RC_OSC_EN      <= 1'b1;
      EXT_OSC_EN     <= 1'b0;
      MAIN_PLL_EN    <= 1'b0;
      AUDIO_PLL_EN   <= 1'b0;
      CORE_CLK_EN    <= 1'b1;
      PERIPH_CLK_EN  <= 1'b1;
      CORE_DOMAIN_EN <= 1'b1;
      RTC_DOMAIN_EN  <= 1'b1;
      LP_STAT        <= CC_LP_RUN;
    end else begin
      RC_OSC_EN      <= ~deep;
      EXT_OSC_EN     <= EXT_OSC_EN_REQ & ~deep;
      MAIN_PLL_EN    <= MAIN_PLL_EN_REQ & ~deep;
      AUDIO_PLL_EN   <= AUDIO_PLL_EN_REQ & ~deep;
      CORE_CLK_EN    <= (lp_reg == CC_LP_RUN);
      PERIPH_CLK_EN  <= ~deep;
      CORE_DOMAIN_EN <= ~deep;
      RTC_DOMAIN_EN  <= 1'b1;
      LP_STAT        <= lp_reg;
    end
  end

  // PLL settings load only while that PLL is not requested
  always_ff @(posedge CLK) begin
    if (RST) begin
      MAIN_PLL_CFG_O  <= CC_PLL_RST;
      AUDIO_PLL_CFG_O <= CC_APLL_RST;
    end else begin
      if (!MAIN_PLL_EN_REQ) begin
        MAIN_PLL_CFG_O  <= MAIN_PLL_CFG;
      end
      if (!AUDIO_PLL_EN_REQ) begin
        AUDIO_PLL_CFG_O <= AUDIO_PLL_CFG;
      end
    end
  end

  // Bus clock ticks: AHB from system clock, APB from AHB ticks
  cc_div u_ahb (
    .clk  (CLK),
    .rst  (RST),
    .step (1'b1),
    .code (AHB_DIV),
    .tick (AHB_TICK)
  );

  cc_div u_apb1 (
    .clk  (CLK),
    .rst  (RST),
    .step (AHB_TICK),
    .code (APB1_DIV),
    .tick (APB1_TICK)
  );

  cc_div u_apb2 (
    .clk  (CLK),
    .rst  (RST),
    .step (AHB_TICK),
    .code (APB2_DIV),
    .tick (APB2_TICK)
  );

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Failure edge while the system clock hangs on the external oscillator
  sequence s_fail_hit;
    fail_rise && !deep && (sw_reg == CC_SW_RUN) &&
      ((SRC_STAT == CC_SRC_EXT) || ((SRC_STAT == CC_SRC_PLL) && MAIN_PLL_CFG_O.ref_ext));
  endsequence

  sequence s_sleep_go;
    LP_ENTER && (LP_MODE == CC_LP_SLEEP) && (lp_reg == CC_LP_RUN);
  endsequence

  a_src_legal: assert property (SRC_STAT != 2'h3)
    else $error("system clock status shows an unknown source");
  a_pll_cfg_hold: assert property (MAIN_PLL_EN_REQ |=> $stable(MAIN_PLL_CFG_O))
    else $error("main PLL settings changed while enabled");
  a_reset_rc: assert property ($past(RST) |-> SRC_STAT == CC_SRC_RC && SRC_GATE == 3'h1)
    else $error("RC clock not selected after reset");
  a_fail_fallback: assert property (s_fail_hit |-> ##[1:8] (SRC_STAT == CC_SRC_RC))
    else $error("no fallback to RC after oscillator failure");
  a_fail_irq: assert property (fail_rise && FAIL_IRQ_EN |=> FAIL_IRQ && FAIL_FLAG)
    else $error("failure interrupt not raised");
  a_ahb_half: assert property ((AHB_DIV == 3'h1)[*4] |-> AHB_TICK != $past(AHB_TICK))
    else $error("AHB tick not alternating at divide by two");
  a_apb_follow: assert property ((APB1_TICK || APB2_TICK) |-> $past(AHB_TICK))
    else $error("APB tick without an AHB tick");
  a_audio_hold: assert property (AUDIO_PLL_EN_REQ |=> $stable(AUDIO_PLL_CFG_O))
    else $error("audio PLL settings changed while enabled");
  a_sleep_core: assert property (s_sleep_go |=> ##1 (!CORE_CLK_EN && PERIPH_CLK_EN))
    else $error("sleep did not stop only the core clock");
  a_stop_off: assert property ((lp_reg == CC_LP_STOP) |=> !RC_OSC_EN && !EXT_OSC_EN && !MAIN_PLL_EN && !CORE_DOMAIN_EN)
    else $error("stop left a source or the core domain running");
  a_standby_off: assert property ((lp_reg == CC_LP_STANDBY) |=> !RC_OSC_EN && !EXT_OSC_EN && RTC_DOMAIN_EN)
    else $error("standby gating wrong");
  a_gate_clean: assert property ($changed(SRC_STAT) |-> $past(SRC_GATE) == 3'h0 && $onehot0(SRC_GATE))
    else $error("source switched without a dead gap");

endmodule

/* core/cc_pkg.sv */
/*
  Shared constants, types and helpers for the system clock controller.
  Assumes a single 25 MHz control clock; source clocks are handled as gates.
*/
package cc_pkg;

  // Control clock rate and the dead time between two source gates
  localparam int          CC_CLK_MHZ  = 25;
  localparam int          CC_GAP_NS   = 80;
  localparam logic [3:0]  CC_GAP_CYC  = 4'((CC_GAP_NS * CC_CLK_MHZ + 999) / 1000);

  // System clock source codes as shown on the status port
  localparam logic [1:0]  CC_SRC_RC   = 2'h0;
  localparam logic [1:0]  CC_SRC_EXT  = 2'h1;
  localparam logic [1:0]  CC_SRC_PLL  = 2'h2;

  // One-hot gate positions
  localparam int          CC_GATE_W   = 3;
  localparam logic [2:0]  CC_GATE_OFF = 3'h0;

  // Divider widths
  localparam int          CC_DIV_W    = 3;
  localparam int          CC_CNT_W    = 8;

  // Reset value of the divider codes
  localparam logic [2:0]  CC_DIV_RST  = 3'h0;

  // Pin synchroniser lanes
  localparam int          CC_PIN_W    = 5;
  localparam int          CC_PIN_RC   = 0;
  localparam int          CC_PIN_EXT  = 1;
  localparam int          CC_PIN_LOCK = 2;
  localparam int          CC_PIN_FAIL = 3;
  localparam int          CC_PIN_WAKE = 4;

  typedef enum logic [1:0] {
    CC_LP_RUN,
    CC_LP_SLEEP,
    CC_LP_STOP,
    CC_LP_STANDBY
  } cc_lp_e;

  typedef enum logic {
    CC_SW_RUN,
    CC_SW_GAP
  } cc_sw_e;

  typedef struct packed {
    logic       ref_ext;
    logic [8:0] mul;
    logic [5:0] div;
  } cc_pll_cfg_s;

  typedef struct packed {
    logic [8:0] mul;
    logic [2:0] div;
  } cc_apll_cfg_s;

  localparam cc_pll_cfg_s  CC_PLL_RST  = '0;
  localparam cc_apll_cfg_s CC_APLL_RST = '0;

  // One-hot gate for a source code
  function automatic logic [2:0] cc_gate(input logic [1:0] src);
    logic [2:0] g;
    g = CC_GATE_OFF;
    case (src)
      CC_SRC_RC:  g = 3'h1;
      CC_SRC_EXT: g = 3'h2;
      CC_SRC_PLL: g = 3'h4;
      default:    g = CC_GATE_OFF;
    endcase
    return g;
  endfunction

  // Terminal count of a divide-by-2^code divider
  function automatic logic [7:0] cc_div_limit(input logic [2:0] code);
    return 8'((9'h1 << code) - 9'h1);
  endfunction

endpackage

/* core/cc_sync.sv */
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes the inputs are asynchronous levels, held longer than two clocks.
*/
`timescale 1ns/100ps
module cc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

/* core/cc_div.sv */
/*
  Power-of-two tick divider: emits one tick every 2^code steps.
  Assumes step comes from logic on the same clock.
*/
`timescale 1ns/100ps
module cc_div
  import cc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                step,
  input  wire logic [CC_DIV_W-1:0] code,
  output logic                     tick
);

  logic [CC_CNT_W-1:0] cnt_reg;
  logic [CC_CNT_W-1:0] limit;

  assign limit = cc_div_limit(code);

  // Count steps, wrap at the limit even after a code change
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (step) begin
      tick    <= (cnt_reg >= limit);
      cnt_reg <= (cnt_reg >= limit) ? '0 : cnt_reg + 8'h1;
    end else begin
      tick    <= 1'b0;
    end
  end

endmodule

/* dv/cc_ext_osc_model.sv */
/*
  Behavioural model of the external fast oscillator at the controller's pins.
  Assumes en comes from the controller and the bench commands slow start or failure.
*/
`timescale 1ns/100ps
module cc_ext_osc_model (
  input  wire logic clk,
  input  wire logic en,
  input  wire logic slow,
  input  wire logic fail_cmd,
  output logic      rdy,
  output logic      fail
);
  int cnt = 0;
  initial begin
    rdy = 1'b0;
    fail = 1'b0;
  end
  // Start-up count; ready drops at once when disabled or broken
  always @(posedge clk) begin
    if (!en || fail_cmd) begin
      cnt <= 0;
      rdy <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      rdy <= (cnt >= (slow ? 20 : 3));
    end
  end
  // Detector level stays up while the failure lasts
  always @(posedge clk) begin
    fail <= fail_cmd && en;
  end
endmodule

/* dv/tb.sv */
/*
  Self-checking bench for the system clock controller.
  Assumes the design under core/ and the oscillator model under dv/.
*/
`timescale 1ns/100ps
module tb;
  import cc_pkg::*;
  logic clk, rst, ext_en_req, pll_en_req, apll_en_req, rc_rdy, pll_lock, irq_en, irq_clr;
  logic lp_enter, wake, slow, fail_cmd, ext_rdy, ext_fail;
  logic [1:0] src_req;
  logic [2:0] ahb_div, apb1_div, apb2_div;
  cc_pll_cfg_s pll_cfg;
  cc_apll_cfg_s apll_cfg;
  cc_lp_e lp_mode;
  logic rc_en, ext_en, pll_en, apll_en, busy, flag, irq, core_en, per_en, dom_en, rtc_en;
  logic ahb_t, apb1_t, apb2_t;
  logic [2:0] gate;
  logic [1:0] stat;
  cc_pll_cfg_s pll_o;
  cc_apll_cfg_s apll_o;
  cc_lp_e lp_stat;
  int errors = 0, cmp_count = 0, cycles = 0, p;
  logic [31:0] rnd = 32'h3945eef9;
  wire [2:0] ticks = {apb2_t, apb1_t, ahb_t};

  cc_clk_ctrl dut (.CLK(clk), .RST(rst), .SRC_REQ(src_req), .EXT_OSC_EN_REQ(ext_en_req),
    .MAIN_PLL_EN_REQ(pll_en_req), .MAIN_PLL_CFG(pll_cfg), .AUDIO_PLL_EN_REQ(apll_en_req),
    .AUDIO_PLL_CFG(apll_cfg), .RC_RDY(rc_rdy), .EXT_RDY(ext_rdy), .PLL_LOCK(pll_lock),
    .EXT_FAIL(ext_fail), .FAIL_IRQ_EN(irq_en), .FAIL_IRQ_CLR(irq_clr), .AHB_DIV(ahb_div),
    .APB1_DIV(apb1_div), .APB2_DIV(apb2_div), .LP_ENTER(lp_enter), .LP_MODE(lp_mode),
    .WAKE(wake), .RC_OSC_EN(rc_en), .EXT_OSC_EN(ext_en), .MAIN_PLL_EN(pll_en),
    .MAIN_PLL_CFG_O(pll_o), .AUDIO_PLL_EN(apll_en), .AUDIO_PLL_CFG_O(apll_o),
    .SRC_GATE(gate), .SRC_STAT(stat), .SW_BUSY(busy), .FAIL_FLAG(flag), .FAIL_IRQ(irq),
    .CORE_CLK_EN(core_en), .PERIPH_CLK_EN(per_en), .CORE_DOMAIN_EN(dom_en),
    .RTC_DOMAIN_EN(rtc_en), .LP_STAT(lp_stat), .AHB_TICK(ahb_t), .APB1_TICK(apb1_t),
    .APB2_TICK(apb2_t));
  cc_ext_osc_model osc (.clk(clk), .en(ext_en), .slow(slow), .fail_cmd(fail_cmd),
    .rdy(ext_rdy), .fail(ext_fail));

  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Waits up to 40 cycles for the reported source to reach a code
  task automatic wait_src(input logic [1:0] s);
    for (int i = 0; i < 40 && stat !== s; i++) @(negedge clk);
  endtask
  // Distance between two ticks of one divider output
  task automatic period(input int sel, output int q);
    int f;
    f = -1;
    q = -1;
    for (int i = 0; i < 300 && q < 0; i++) begin
      @(negedge clk);
      if (ticks[sel] === 1'b1) begin
        if (f >= 0) q = i - f;
        f = i;
      end
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    logic [2:0] a, b, c;
    {rst, ext_en_req, pll_en_req, apll_en_req, pll_lock, irq_en, irq_clr} = 7'h40;
    {lp_enter, wake, slow, fail_cmd, src_req, ahb_div, apb1_div, apb2_div} = '0;
    {rc_rdy, pll_cfg, apll_cfg, lp_mode} = '0;
    rc_rdy = 1'b1;
    lp_mode = CC_LP_RUN;
    cyc(6);
    rst <= 1'b0;
    @(negedge clk);
    chk(stat, CC_SRC_RC);
    chk(gate, 3'h1);
    chk(rc_en, 1'b1);
    // PLL settings load while disabled; RC reference
    rnd = xs(rnd);
    @(posedge clk);
    pll_cfg <= cc_pll_cfg_s'({1'b0, rnd[14:0]});
    apll_cfg <= cc_apll_cfg_s'(rnd[27:16]);
    cyc(3);
    pll_en_req <= 1'b1;
    apll_en_req <= 1'b1;
    src_req <= CC_SRC_PLL;
    cyc(12);
    @(negedge clk);
    chk(pll_o, {1'b0, rnd[14:0]});
    chk(apll_o, rnd[27:16]);
    chk({pll_en, apll_en}, 2'h3);
    chk(stat, CC_SRC_RC);
    @(posedge clk);
    pll_lock <= 1'b1;
    wait_src(CC_SRC_PLL);
    chk(gate, 3'h4);
    // Second reset in mid-run returns to the RC clock
    @(posedge clk);
    rst <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk({stat, gate}, {CC_SRC_RC, 3'h1});
    @(posedge clk);
    rst <= 1'b0;
    wait_src(CC_SRC_PLL);
    chk(stat, CC_SRC_PLL);
    // Slow oscillator start, then a timed switch from PLL to external
    slow <= 1'b1;
    ext_en_req <= 1'b1;
    for (int i = 0; i < 60 && ext_rdy !== 1'b1; i++) @(posedge clk);
    cyc(4);
    src_req <= CC_SRC_EXT;
    cyc(2);
    @(negedge clk);
    chk({busy, gate}, {1'b1, 3'h0});
    cyc(2);
    @(negedge clk);
    chk({stat, gate}, {CC_SRC_EXT, 3'h2});
    // Oscillator failure with the interrupt enabled
    @(posedge clk);
    irq_en <= 1'b1;
    fail_cmd <= 1'b1;
    wait_src(CC_SRC_RC);
    chk({gate, flag, irq}, {3'h1, 2'h3});
    cyc(10);
    @(negedge clk);
    chk(stat, CC_SRC_RC);
    @(posedge clk);
    irq_clr <= 1'b1;
    @(posedge clk);
    irq_clr <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk({flag, irq}, 2'h0);
    // Recovery, then a second failure with the interrupt masked
    @(posedge clk);
    fail_cmd <= 1'b0;
    slow <= 1'b0;
    irq_en <= 1'b0;
    wait_src(CC_SRC_EXT);
    chk(stat, CC_SRC_EXT);
    @(posedge clk);
    fail_cmd <= 1'b1;
    wait_src(CC_SRC_RC);
    chk({flag, irq}, 2'h2);
    @(posedge clk);
    fail_cmd <= 1'b0;
    src_req <= CC_SRC_RC;
    // Random divider settings; APB1 kept at most half of AHB
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      a = {1'b0, rnd[1:0]};
      b = {1'b0, rnd[3:2]} | 3'h1;
      c = {1'b0, rnd[5:4]};
      @(posedge clk);
      ahb_div <= a;
      apb1_div <= b;
      apb2_div <= c;
      cyc(150);
      period(0, p);
      chk(p, 1 << a);
      period(1, p);
      chk(p, 1 << (a + b));
      period(2, p);
      chk(p, 1 << (a + c));
    end
    // Each low-power mode, with both fast sources requested on
    @(posedge clk);
    pll_en_req <= 1'b1;
    ext_en_req <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      lp_mode <= cc_lp_e'(m);
      lp_enter <= 1'b1;
      @(posedge clk);
      lp_enter <= 1'b0;
      cyc(4);
      @(negedge clk);
      chk({lp_stat, core_en, rtc_en}, {2'(m), 2'h1});
      if (m == 1) chk({per_en, rc_en}, 2'h3);
      if (m == 2) chk({rc_en, ext_en, pll_en, dom_en}, 4'h0);
      if (m == 3) chk({rc_en, ext_en}, 2'h0);
      @(posedge clk);
      wake <= 1'b1;
      cyc(4);
      wake <= 1'b0;
      for (int i = 0; i < 40 && gate !== 3'h1; i++) @(negedge clk);
      cyc(1);
      @(negedge clk);
      chk({lp_stat, core_en, gate}, {CC_LP_RUN, 1'b1, 3'h1});
    end
    stop_test();
  end
endmodule
